// file: src/dptr_cfg.svh
// Constants of the data pointer address unit: selectors, codes, fields.
// Assumes the decode stage and this unit share one clock and reset.
`ifndef DPTR_CFG_SVH
`define DPTR_CFG_SVH

// Register space decode
`define PTR_MODULE    4'h3
`define IDX_DP0       4'h0
`define IDX_DP1       4'h1
`define IDX_FBASE     4'h2
`define IDX_FDISP     4'h3
`define IDX_CTRL      4'h4
`define DISCARD_MOD   4'h6
`define DISCARD_IDX   4'h7

// Source pointer select codes
`define SEL_DP0       2'h0
`define SEL_DP1       2'h1
`define SEL_FRAME     2'h2
`define SEL_RSVD      2'h3

// Pointer control register fields
`define SDPS_LSB      0
`define SDPS_MSB      1
`define WS_LSB        2
`define WS_MSB        4
`define WS_FRAME      2

// Reset values, then the one and zero constants
`define PTR_RST       17'h00000
`define DISP_RST      9'h000
`define WS_RST        3'h0
`define SEL_RST       2'h0
`define ONE16         16'h0001
`define ONE8          8'h01
`define ZERO8         8'h00
`define ZERO11        11'h000

`endif

// file: src/dptr_pkg.sv
// Types shared by the data pointer address unit.
// Assumes nothing beyond the constant header.
package dptr_pkg;

  // Adjustment request carried by a memory transfer
  typedef enum logic [1:0] {
    ADJ_NONE = 2'h0,
    ADJ_INC  = 2'h1,
    ADJ_DEC  = 2'h2
  } adj_e;

  typedef logic [16:0] ptr_t;
  typedef logic [8:0]  disp_t;
  typedef logic [15:0] view_t;

endpackage

// file: src/data_pointer_address_unit.sv
// Data pointer address unit: two data pointers and a frame pointer.
// Assumes decode and memory port run on clk; one transfer per cycle.
`timescale 1ns/1ns
`include "dptr_cfg.svh"

module data_pointer_address_unit
  import dptr_pkg::*;
#(
  parameter int NDP = 2
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_module,
  input  wire logic [3:0]  reg_index,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_ptr,
  input  wire adj_e        acc_adj,
  input  wire logic        fetch_overlap,
  output logic [15:0]      rd_data_q,
  output logic             mem_valid_q,
  output logic             mem_write_q,
  output logic             mem_word_q,
  output logic [15:0]      mem_addr_q,
  output logic [1:0]       src_sel_q,
  output logic             src_active_q,
  output logic [2:0]       word_sel_q
);

  // Window helpers: one place decides which bits a mode sees
  function automatic view_t view17(input ptr_t p, input logic ws);
    view17 = ws ? p[16:1] : p[15:0];
  endfunction

  function automatic ptr_t put17(input ptr_t p, input view_t v,
                                 input logic ws);
    put17 = ws ? {v, p[0]} : {p[16], v};
  endfunction

  function automatic logic [7:0] view9(input disp_t d, input logic ws);
    view9 = ws ? d[8:1] : d[7:0];
  endfunction

  function automatic disp_t put9(input disp_t d, input logic [7:0] v,
                                 input logic ws);
    put9 = ws ? {v, d[0]} : {d[8], v};
  endfunction

  // Reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Pointer storage
  ptr_t        dp_q [NDP];
  ptr_t        fbase_q;
  disp_t       fdisp_q;
  ptr_t        dp_d [NDP];
  ptr_t        fbase_d;
  disp_t       fdisp_d;
  logic [1:0]  sel_d;
  logic        act_d;
  logic [2:0]  ws_d;
  logic [15:0] rdat_d;

  // Register space decode
  wire hit_ptr  = reg_module == `PTR_MODULE;
  wire wr_fbase = reg_wr && hit_ptr && reg_index == `IDX_FBASE;
  wire wr_fdisp = reg_wr && hit_ptr && reg_index == `IDX_FDISP;
  wire wr_ctrl  = reg_wr && hit_ptr && reg_index == `IDX_CTRL;
  // Discard sink decodes but owns no storage, so it changes nothing
  wire wr_null  = reg_wr && reg_module == `DISCARD_MOD
                         && reg_index == `DISCARD_IDX;

  // Transfer decode; the reserved select code never touches a pointer
  wire acc_ok   = acc_valid && acc_ptr != `SEL_RSVD;
  wire do_adj   = acc_ok && acc_adj != ADJ_NONE;
  wire mem_wr   = acc_ok && acc_write;
  wire fr_adj   = do_adj && acc_ptr == `SEL_FRAME;

  // Frame pointer views; adjustment only ever lands in the displacement
  wire         ws_fr   = word_sel_q[`WS_FRAME];
  wire view_t  fb_view = view17(fbase_q, ws_fr);
  wire [7:0]   fd_view = view9(fdisp_q, ws_fr);
  wire [7:0]   fd_adj  = (acc_adj == ADJ_DEC) ? fd_view - `ONE8
                                              : fd_view + `ONE8;
  wire view_t  fr_cur  = fb_view + {`ZERO8, fd_view};
  wire view_t  fr_pre  = fb_view + {`ZERO8, fd_adj};

  // Per pointer: current address, adjusted address, write decode
  view_t addr_cur [4];
  view_t addr_pre [4];
  logic  wr_dp    [NDP];

  genvar g;
  generate
    for (g = 0; g < NDP; g++) begin : g_dp
      wire view_t cur = view17(dp_q[g], word_sel_q[g]);
      // Wrap stays inside the 16-bit window of the active mode
      wire view_t stp = (acc_adj == ADJ_DEC) ? cur - `ONE16
                                             : cur + `ONE16;
      wire hit = do_adj && acc_ptr == 2'(g);
      assign wr_dp[g]    = reg_wr && hit_ptr && reg_index == 4'(g);
      assign addr_cur[g] = cur;
      assign addr_pre[g] = hit ? stp : cur;
      // Register write has priority; the issuer never does both at once
      assign dp_d[g] = wr_dp[g] ? put17(dp_q[g], reg_wdata,
                                        word_sel_q[g])
                     : hit      ? put17(dp_q[g], stp,
                                        word_sel_q[g])
                     : dp_q[g];

      always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          dp_q[g] <= `PTR_RST;
        end else begin
          dp_q[g] <= dp_d[g];
        end
      end
    end
  endgenerate

  assign addr_cur[`SEL_FRAME] = fr_cur;
  assign addr_pre[`SEL_FRAME] = fr_adj ? fr_pre : fr_cur;
  assign addr_cur[`SEL_RSVD]  = fr_cur;
  assign addr_pre[`SEL_RSVD]  = fr_cur;

  // Frame base only moves on a register write
  assign fbase_d = wr_fbase ? put17(fbase_q, reg_wdata, ws_fr)
                            : fbase_q;
  assign fdisp_d = wr_fdisp ? put9(fdisp_q, reg_wdata[7:0], ws_fr)
                 : fr_adj   ? put9(fdisp_q, fd_adj, ws_fr)
                 : fdisp_q;

  // Width-select only changes the view, never the stored bits
  assign ws_d = wr_ctrl ? reg_wdata[`WS_MSB:`WS_LSB] : word_sel_q;

  // Source select: control write, then register write, then memory write
  wire ptr_reg_wr = wr_dp[0] || wr_dp[1] || wr_fbase || wr_fdisp;
  wire [1:0] reg_sel = wr_dp[0] ? `SEL_DP0
                     : wr_dp[1] ? `SEL_DP1
                     : `SEL_FRAME;
  assign sel_d = wr_ctrl    ? reg_wdata[`SDPS_MSB:`SDPS_LSB]
               : ptr_reg_wr ? reg_sel
               : mem_wr     ? acc_ptr
               : src_sel_q;
  // A fresh selection in the same cycle outranks the code fetch drop
  wire sel_set = wr_ctrl || ptr_reg_wr || mem_wr;
  assign act_d = sel_set ? 1'b1
               : fetch_overlap ? 1'b0
               : src_active_q;

  // Writes use the pre-adjusted address; reads use the active source
  wire view_t rd_addr = addr_cur[src_sel_q];
  wire view_t wr_addr = addr_pre[acc_ptr];
  wire        wr_word = (acc_ptr == `SEL_FRAME) ? ws_fr
                                                : word_sel_q[acc_ptr[0]];
  wire        rd_word = (src_sel_q == `SEL_FRAME) ? ws_fr
                                                  : word_sel_q[src_sel_q[0]];
  wire        rd_go   = acc_valid && !acc_write && src_active_q
                        && src_sel_q != `SEL_RSVD;

  // Register read mux; reads see each pointer through its window
  always_comb begin
    rdat_d = 16'h0000;
    if (reg_rd && hit_ptr) begin
      case (reg_index)
        `IDX_DP0:   rdat_d = addr_cur[0];
        `IDX_DP1:   rdat_d = addr_cur[1];
        `IDX_FBASE: rdat_d = fb_view;
        `IDX_FDISP: rdat_d = {`ZERO8, fd_view};
        `IDX_CTRL:  rdat_d = {`ZERO11, word_sel_q, src_sel_q};
        default:    rdat_d = 16'h0000;
      endcase
    end
  end

  // Frame registers and control state
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fbase_q      <= `PTR_RST;
      fdisp_q      <= `DISP_RST;
      word_sel_q   <= `WS_RST;
      src_sel_q    <= `SEL_RST;
      src_active_q <= 1'b0;
    end else begin
      fbase_q      <= fbase_d;
      fdisp_q      <= fdisp_d;
      word_sel_q   <= ws_d;
      src_sel_q    <= sel_d;
      src_active_q <= act_d;
    end
  end

  // Memory port and read data, registered so outputs come from flops
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_valid_q <= 1'b0;
      mem_write_q <= 1'b0;
      mem_word_q  <= 1'b0;
      mem_addr_q  <= 16'h0000;
      rd_data_q   <= 16'h0000;
    end else begin
      mem_valid_q <= mem_wr || rd_go;
      mem_write_q <= mem_wr;
      mem_word_q  <= mem_wr ? wr_word : rd_word;
      mem_addr_q  <= mem_wr ? wr_addr : rd_addr;
      rd_data_q   <= rdat_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  base_holds_a: assert property (!wr_fbase |=> $stable(fbase_q))
    else $error("frame base moved without a register write");
  write_sel_a: assert property (mem_wr && !wr_ctrl && !ptr_reg_wr
                                |=> src_sel_q == $past(acc_ptr)
                                    && src_active_q)
    else $error("memory write did not select its pointer");
  regwr_sel_a: assert property (wr_dp[1] && !wr_ctrl
                                |=> src_sel_q == `SEL_DP1)
    else $error("pointer write did not select it");
  fetch_drop_a: assert property (fetch_overlap && !sel_set
                                 |=> !src_active_q ##1 !mem_valid_q
                                     || $past(acc_write))
    else $error("selection not dropped on code fetch");
  byte_wrap_a: assert property (do_adj && acc_ptr == `SEL_DP0
                                && !word_sel_q[0] && !wr_dp[0]
                                |=> dp_q[0][16] == $past(dp_q[0][16]))
    else $error("byte adjustment carried into bit 16");
  pre_write_a: assert property (mem_wr && acc_ptr == `SEL_DP0
                                && acc_adj == ADJ_INC
                                |=> mem_addr_q == $past(addr_cur[0])
                                    + `ONE16 && mem_write_q)
    else $error("write did not use pre-incremented address");
  post_read_a: assert property (rd_go && src_sel_q == `SEL_DP1
                                |=> mem_addr_q == $past(addr_cur[1]))
    else $error("read did not use active source address");
  mode_keep_a: assert property (wr_ctrl && !ptr_reg_wr && !do_adj
                                |=> dp_q[0] == $past(dp_q[0])
                                    && dp_q[1] == $past(dp_q[1]))
    else $error("width change altered stored pointer bits");
  null_sink_a: assert property (wr_null && !acc_valid
                                |=> $stable(dp_q[0]) && $stable(fdisp_q)
                                    && $stable(src_sel_q))
    else $error("discard write changed state");
  frame_addr_a: assert property (rd_go && src_sel_q == `SEL_FRAME
                                 |=> mem_addr_q == $past(fb_view)
                                     + {`ZERO8, $past(fd_view)})
    else $error("frame address is not base plus displacement");

  // Control field layout and the width flag seen on the memory port
  ctrl_field_a: assert property (wr_ctrl
                                 |=> word_sel_q == $past(reg_wdata[4:2]))
    else $error("control write did not load width selects");

  mem_word_a: assert property (mem_wr && acc_ptr == `SEL_DP1
                               |=> mem_word_q == $past(word_sel_q[1]))
    else $error("memory width flag does not follow its select");

  // Register reads go through the window of the current mode
  word_view_a: assert property (reg_rd && hit_ptr
                                && reg_index == `IDX_DP0 && word_sel_q[0]
                                |=> rd_data_q == $past(dp_q[0][16:1]))
    else $error("word mode read not taken from upper bits");

  byte_view_a: assert property (reg_rd && hit_ptr
                                && reg_index == `IDX_DP0 && !word_sel_q[0]
                                |=> rd_data_q == $past(dp_q[0][15:0]))
    else $error("byte mode read not taken from lower bits");

  disp_view_a: assert property (reg_rd && hit_ptr
                                && reg_index == `IDX_FDISP
                                |=> rd_data_q == {`ZERO8, $past(fd_view)})
    else $error("displacement read not taken through its window");

  // Select codes set by pointer register writes
  sel_dp0_a: assert property (wr_dp[0] && !wr_ctrl
                              |=> src_sel_q == `SEL_DP0)
    else $error("pointer 0 write did not select it");

  sel_frame_a: assert property ((wr_fbase || wr_fdisp) && !wr_ctrl
                                |=> src_sel_q == `SEL_FRAME)
    else $error("frame register write did not select the frame");

  // Wrap limits: nothing outside the active window may change
  disp_wrap_a: assert property (fr_adj && !ws_fr && !wr_fdisp
                                |=> fdisp_q[8] == $past(fdisp_q[8]))
    else $error("byte displacement adjust carried into bit 8");

  word_adj_a: assert property (do_adj && acc_ptr == `SEL_DP1
                               && word_sel_q[1] && !wr_dp[1]
                               |=> dp_q[1][0] == $past(dp_q[1][0]))
    else $error("word adjustment touched the byte-only bit");

  // Reads follow the active source and adjust only afterwards
  post_adj_a: assert property (acc_ok && !acc_write
                               && acc_ptr == `SEL_DP0
                               && acc_adj == ADJ_INC
                               && !wr_dp[0] && !wr_ctrl
                               |=> addr_cur[0] == $past(addr_cur[0])
                                   + `ONE16)
    else $error("read did not post-increment its pointer");

  idle_read_a: assert property (acc_valid && !acc_write
                                && !src_active_q
                                |=> !mem_valid_q)
    else $error("read issued with no active source");

  // A transfer naming no pointer leaves every pointer alone
  no_ptr_a: assert property (acc_valid && acc_ptr == `SEL_RSVD && !reg_wr
                             |=> $stable(dp_q[0]) && $stable(dp_q[1])
                                 && $stable(fdisp_q) && !mem_write_q)
    else $error("reserved pointer code changed a pointer");

  word_read_c: cover property (rd_go && word_sel_q[0]);
  byte_wrap_c: cover property (do_adj && acc_ptr == `SEL_DP1
                               && acc_adj == ADJ_INC && !word_sel_q[1]
                               && addr_cur[1] == 16'hFFFF);
  discard_c: cover property (wr_null);
  frame_adj_c: cover property (fr_adj ##1 rd_go);
  fetch_drop_c: cover property (src_active_q && fetch_overlap && !sel_set);

endmodule

// file: test/mem_port_model.sv
// Data memory port model: counts issued accesses, keeps last write address.
// Assumes the unit's memory outputs are registered on clk.
`timescale 1ns/1ns

module mem_port_model
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        mem_valid_q,
  input  wire logic        mem_write_q,
  input  wire logic [15:0] mem_addr_q,
  output int               n_access,
  output logic [15:0]      last_wr_addr
);
  // One pointer owns the single port, so at most one access per edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_access     <= 0;
      last_wr_addr <= 16'h0000;
    end else if (mem_valid_q === 1'b1) begin
      n_access <= n_access + 1;
      if (mem_write_q === 1'b1)
        last_wr_addr <= mem_addr_q;
    end
  end
endmodule

// file: test/test_data_pointer_address_unit.sv
// Bench for the data pointer address unit; each scenario is a task.
// Assumes one clock; stimulus never adjusts and writes one pointer at once.
`timescale 1ns/1ns
`include "dptr_cfg.svh"

module test_data_pointer_address_unit import dptr_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_module = 4'h0, reg_index = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, rd_data_q, mem_addr_q, last_wr_addr;
  logic acc_valid = 1'b0, acc_write = 1'b0, fetch_overlap = 1'b0;
  logic [1:0] acc_ptr = 2'h0, src_sel_q;
  adj_e acc_adj = ADJ_NONE;
  logic mem_valid_q, mem_write_q, mem_word_q, src_active_q;
  logic [2:0] word_sel_q;
  int miscompares = 0, n_compared = 0, n_access;

  data_pointer_address_unit data_pointer_address_unit_inst (
    .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_module(reg_module), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_ptr(acc_ptr),
    .acc_adj(acc_adj), .fetch_overlap(fetch_overlap),
    .rd_data_q(rd_data_q), .mem_valid_q(mem_valid_q),
    .mem_write_q(mem_write_q), .mem_word_q(mem_word_q),
    .mem_addr_q(mem_addr_q), .src_sel_q(src_sel_q),
    .src_active_q(src_active_q), .word_sel_q(word_sel_q));

  mem_port_model mem_port_model_inst (
    .clk(clk), .nrst(nrst), .mem_valid_q(mem_valid_q),
    .mem_write_q(mem_write_q), .mem_addr_q(mem_addr_q),
    .n_access(n_access), .last_wr_addr(last_wr_addr));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic finish_test;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write; the strobe drops a cycle later so calls chain cleanly
  task automatic wr(input logic [3:0] m, input logic [3:0] i,
                    input logic [15:0] d);
    @(posedge clk);
    reg_wr     <= 1'b1;
    reg_module <= m;
    reg_index  <= i;
    reg_wdata  <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Let the edge's updates settle so a following check sees them
    #1;
  endtask

  // Read data stands one cycle only, so it is sampled just after the edge
  task automatic rd(input logic [3:0] m, input logic [3:0] i,
                    input logic [15:0] e);
    @(posedge clk);
    reg_rd     <= 1'b1;
    reg_module <= m;
    reg_index  <= i;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({4'h0, rd_data_q}, {4'h0, e});
  endtask

  // Transfer; ef holds expected valid, write and word flags
  task automatic acc(input logic w, input logic [1:0] p, input adj_e a,
                     input logic [2:0] ef, input logic [15:0] ea);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_ptr   <= p;
    acc_adj   <= a;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1 chk({19'h00000, mem_valid_q}, {19'h00000, ef[2]});
    if (ef[2])
      chk({2'h0, mem_write_q, mem_word_q, mem_addr_q}, {2'h0, ef[1:0], ea});
  endtask

  task automatic t_reset;
    chk({17'h00000, word_sel_q}, 20'h00000);
    chk({19'h00000, src_active_q}, 20'h00000);
    acc(1'b0, 2'h0, ADJ_NONE, 3'h0, 16'h0000);
    rd(`PTR_MODULE, `IDX_DP0, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_window;
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0000);
    wr(`PTR_MODULE, `IDX_DP0, 16'h2345);
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0004);
    chk({17'h00000, word_sel_q}, 20'h00001);
    wr(`PTR_MODULE, `IDX_DP0, 16'h2345);
    rd(`PTR_MODULE, `IDX_DP0, 16'h2345);
    acc(1'b1, 2'h0, ADJ_NONE, 3'h7, 16'h2345);
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0000);
    rd(`PTR_MODULE, `IDX_DP0, 16'h468B);
    $display("test window done");
  endtask

  // A carry past bit 15 would show as 8000 in the word view
  task automatic t_wrap;
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0000);
    wr(`PTR_MODULE, `IDX_DP1, 16'hFFFF);
    acc(1'b0, 2'h1, ADJ_INC, 3'h4, 16'hFFFF);
    rd(`PTR_MODULE, `IDX_DP1, 16'h0000);
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0008);
    rd(`PTR_MODULE, `IDX_DP1, 16'h0000);
    acc(1'b1, 2'h1, ADJ_DEC, 3'h7, 16'hFFFF);
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0000);
    rd(`PTR_MODULE, `IDX_DP1, 16'hFFFE);
    $display("test wrap done");
  endtask

  task automatic t_prepost;
    wr(`PTR_MODULE, `IDX_DP0, 16'h0010);
    wr(`PTR_MODULE, `IDX_DP1, 16'h0020);
    chk({18'h00000, src_sel_q}, {18'h00000, `SEL_DP1});
    acc(1'b1, 2'h0, ADJ_INC, 3'h6, 16'h0011);
    chk({18'h00000, src_sel_q}, {18'h00000, `SEL_DP0});
    acc(1'b0, 2'h0, ADJ_INC, 3'h4, 16'h0011);
    acc(1'b0, 2'h0, ADJ_DEC, 3'h4, 16'h0012);
    rd(`PTR_MODULE, `IDX_DP0, 16'h0011);
    $display("test prepost done");
  endtask

  task automatic t_frame;
    wr(`PTR_MODULE, `IDX_FBASE, 16'h0100);
    wr(`PTR_MODULE, `IDX_FDISP, 16'h0005);
    chk({18'h00000, src_sel_q}, {18'h00000, `SEL_FRAME});
    acc(1'b0, 2'h2, ADJ_INC, 3'h4, 16'h0105);
    rd(`PTR_MODULE, `IDX_FBASE, 16'h0100);
    rd(`PTR_MODULE, `IDX_FDISP, 16'h0006);
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0012);
    acc(1'b1, 2'h2, ADJ_DEC, 3'h7, 16'h0082);
    wr(`PTR_MODULE, `IDX_CTRL, 16'h0000);
    rd(`PTR_MODULE, `IDX_FDISP, 16'h0004);
    $display("test frame done");
  endtask

  task automatic t_refuse;
    wr(`PTR_MODULE, `IDX_DP0, 16'h0030);
    wr(`DISCARD_MOD, `DISCARD_IDX, 16'hBEEF);
    rd(`PTR_MODULE, `IDX_DP0, 16'h0030);
    rd(4'h5, 4'h0, 16'h0000);
    @(posedge clk);
    fetch_overlap <= 1'b1;
    @(posedge clk);
    fetch_overlap <= 1'b0;
    #1 chk({19'h00000, src_active_q}, 20'h00000);
    acc(1'b0, 2'h0, ADJ_NONE, 3'h0, 16'h0000);
    chk(n_access[19:0], 20'h00008);
    chk({4'h0, last_wr_addr}, 20'h00082);
    $display("test refuse done");
  endtask

  // Whole run is well under 1500 cycles
  initial begin
    #6000;
    miscompares++;
    finish_test;
  end

  // Stimulus never adjusts and writes one pointer in a transfer
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_window;
    t_wrap;
    t_prepost;
    t_frame;
    t_refuse;
    finish_test;
  end
endmodule
